// *** dv/lcdhp_checker_assertions.sv ***
`timescale 1ns/1ps
// Host port timing and display state checks.
module lcdhp_checker (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic reset_low_input_n_in,
  input wire lcdhp_pkg::lcdhp_bus_s bus_in,
  input wire logic [7:0] host_data_bus_in,
  input wire logic host_data_bus_oe_out,
  input wire logic [7:0] ram_write_data_out,
  input wire logic ram_write_out,
  input wire logic [5:0] start_line_out,
  input wire logic display_on_out
);
  logic sel, rd;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // Chip select decode and selected read strobe.
  assign sel = !bus_in.select_low_a && !bus_in.select_low_b && bus_in.select_high_c;
  assign rd = sel && bus_in.rd_wr && bus_in.strobe;
  chk_oe_follow: assert property (host_data_bus_oe_out == $past(rd)) else $error("oe");
  chk_oe_idle: assert property (!sel |=> !host_data_bus_oe_out) else $error("oe idle");
  chk_wr_pulse: assert property (sel && !bus_in.rd_wr && bus_in.reg_sel && bus_in.strobe
    ##1 !bus_in.strobe |=> ram_write_out) else $error("wr");
  chk_wr_once: assert property (ram_write_out |=> !ram_write_out) else $error("wr long");
  chk_wr_data: assert property (ram_write_out |-> ram_write_data_out == $past(host_data_bus_in, 2))
    else $error("wr data");
  chk_pin_reset: assert property (!reset_low_input_n_in |=> !display_on_out && start_line_out == 6'h00)
    else $error("pin");
  chk_line_set: assert property (sel && !bus_in.rd_wr && !bus_in.reg_sel && bus_in.strobe
    && reset_low_input_n_in && host_data_bus_in[7:6] == 2'h3 ##1 !bus_in.strobe
    |=> {2'h3, start_line_out} == $past(host_data_bus_in, 2)) else $error("line");
  chk_state_hold: assert property (reset_low_input_n_in && !$fell(bus_in.strobe)
    |=> $stable(start_line_out) && $stable(display_on_out)) else $error("hold");
  cover property (ram_write_out);
  cover property (host_data_bus_oe_out);
  cover property ($fell(display_on_out));
endmodule
bind lcdhp_segment_host_port lcdhp_checker chk_i (.*);

// *** dv/lcdhp_host_model.sv ***
`timescale 1ns/1ps
// Host processor: one strobed access at a time, alternation flips every 8 cycles.
module lcdhp_host_model (
  input wire logic clk_in,
  output lcdhp_pkg::lcdhp_bus_s bus_out,
  output logic [7:0] data_out,
  output logic alt_out
);
  initial {bus_out, data_out, alt_out} = {6'h30, 8'h5A, 1'b0};
  always begin
    repeat (8) @(posedge clk_in);
    #1 alt_out = !alt_out;
  end
  task automatic access(input logic [2:0] cs, input logic rd, input logic rs, input logic [7:0] d);
    @(posedge clk_in);
    #1 bus_out = {cs, rd, rs, 1'b1};
    data_out = d;
    repeat (3) @(posedge clk_in);
    #1 bus_out.strobe = 1'b0;
    @(posedge clk_in);
    #1 bus_out = 6'h30;
    data_out = ~d;
  endtask
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic reset_low_input_n_in = 1'b0;
  logic on = 1'b0;
  logic seg_chk = 1'b0;
  logic column_order_in = 1'b1;
  logic alt_q, ord_q, on_q;
  logic [63:0] ram_row_in = 64'h0;
  logic [63:0] row_q, segment_on_out;
  lcdhp_pkg::lcdhp_bias_t [63:0] segment_outputs_out;
  logic [7:0] ram_read_data_in = 8'h00;
  logic [7:0] host_data_bus_in, host_data_bus_out, ram_write_data_out, v;
  logic host_data_bus_oe_out, ram_write_out, alternation_in, display_on_out, oe_q;
  logic [5:0] start_line_out;
  lcdhp_pkg::lcdhp_bus_s bus_in;
  logic [7:0] q[$];
  int num_errors = 0;
  int total_checks = 0;
  lcdhp_host_model host (.clk_in, .bus_out(bus_in), .data_out(host_data_bus_in), .alt_out(alternation_in));
  lcdhp_segment_host_port uut (.*);
  task automatic cmp(input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t exp %h got %h", $time, e, g);
    end
  endtask
  // Compares the segment outputs with the rule built from last cycle's inputs.
  task automatic cmp_seg(input logic a, input logic o, input logic d, input logic [63:0] r);
    logic [63:0] e_on;
    lcdhp_pkg::lcdhp_bias_t [63:0] e_b;
    for (int i = 0; i < 64; i++) begin
      e_on[i] = d && (o ? r[i] : r[63 - i]);
      e_b[i] = a ? (e_on[i] ? 2'h0 : 2'h2) : (e_on[i] ? 2'h3 : 2'h1);
    end
    total_checks++;
    if (segment_on_out !== e_on || segment_outputs_out !== e_b) begin
      num_errors++;
      $display("MISMATCH %0t segment outputs", $time);
    end
  endtask
  // Notes the expected byte of a selected read or data write, then runs the access.
  task automatic io(input logic [2:0] cs, input logic rd, input logic rs, input logic [7:0] d);
    if (cs == 3'h1 && (rd || rs)) q.push_back(!rs ? {2'h0, !on, !reset_low_input_n_in, 4'h0} : rd ? ram_read_data_in : d);
    host.access(cs, rd, rs, d);
  endtask
  task automatic tally_and_finish;
    if (q.size() != 0) begin
      num_errors++;
      $display("MISMATCH %0t %0d results never appeared", $time, q.size());
    end
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Clock and watchdog.
  initial forever #5 clk_in = !clk_in;
  initial begin
    #20us;
    num_errors++;
    tally_and_finish();
  end
  // A write pulse or a fresh read takes the oldest note.
  always @(posedge clk_in) begin
    oe_q <= host_data_bus_oe_out;
    alt_q <= alternation_in;
    ord_q <= column_order_in;
    on_q <= on;
    row_q <= ram_row_in;
    if (ram_write_out) cmp(q.size() != 0 ? q.pop_front() : 8'hXX, ram_write_data_out);
    if (host_data_bus_oe_out && !oe_q) cmp(q.size() != 0 ? q.pop_front() : 8'hXX, host_data_bus_out);
    if (seg_chk) cmp_seg(alt_q, ord_q, on_q, row_q);
  end
  initial begin
    v = 8'($urandom(32'h8E28));
    repeat (16) @(posedge clk_in);
    #1 srst_in = 1'b0;
    io(3'h1, 1'b1, 1'b0, 8'h00);
    reset_low_input_n_in = 1'b1;
    seg_chk = 1'b1;
    ram_row_in = {$urandom, $urandom};
    for (int i = 0; i < 8; i++) io(i[2:0], 1'b0, i[0], 8'h3F);
    io(3'h1, 1'b1, 1'b0, 8'h00);
    $display("reset and select tests done");
    io(3'h1, 1'b0, 1'b0, 8'h3F);
    on = 1'b1;
    v = 8'($urandom);
    io(3'h1, 1'b0, 1'b0, {2'h3, v[5:0]});
    io(3'h1, 1'b0, 1'b0, {2'h1, v[7:2]});
    io(3'h1, 1'b1, 1'b0, 8'h00);
    cmp({2'h0, start_line_out}, {2'h0, v[5:0]});
    repeat (8) begin
      ram_read_data_in = 8'($urandom);
      column_order_in = 1'($urandom);
      ram_row_in = {$urandom, $urandom};
      io(3'h1, 1'b0, 1'b1, 8'($urandom));
      io(3'h1, 1'b1, 1'b1, 8'h00);
    end
    reset_low_input_n_in = 1'b0;
    @(posedge clk_in);
    #1 on = 1'b0;
    io(3'h1, 1'b1, 1'b0, 8'h00);
    cmp({2'h0, start_line_out}, 8'h00);
    reset_low_input_n_in = 1'b1;
    $display("data and pin reset tests done");
    tally_and_finish();
  end
endmodule

// *** hw/lcd_segment_host_port.sv ***
`timescale 1ns/1ps
`include "lcdhp_defines.svh"

module lcdhp_segment_host_port #(
  parameter int SEG_N = `LCDHP_SEG_N
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic reset_low_input_n_in,
  input wire lcdhp_pkg::lcdhp_bus_s bus_in,
  input wire logic [`LCDHP_DATA_W-1:0] host_data_bus_in,
  output logic [`LCDHP_DATA_W-1:0] host_data_bus_out,
  output logic host_data_bus_oe_out,
  input wire logic alternation_in,
  input wire logic column_order_in,
  input wire logic [SEG_N-1:0] ram_row_in,
  input wire logic [`LCDHP_DATA_W-1:0] ram_read_data_in,
  output logic [`LCDHP_DATA_W-1:0] ram_write_data_out,
  output logic ram_write_out,
  output logic [`LCDHP_LINE_W-1:0] start_line_out,
  output logic display_on_out,
  output logic [SEG_N-1:0] segment_on_out,
  output lcdhp_pkg::lcdhp_bias_t [SEG_N-1:0] segment_outputs_out
);

  lcdhp_pkg::lcdhp_phase_e phase_reg, phase_next;
  logic [`LCDHP_DATA_W-1:0] wdata_reg, wdata_next;
  logic rs_reg, rs_next;
  logic disp_on_reg, disp_on_next;
  logic [`LCDHP_LINE_W-1:0] start_reg, start_next;
  logic [`LCDHP_DATA_W-1:0] dout_reg, dout_next;
  logic oe_reg, oe_next;
  logic ramwr_reg, ramwr_next;
  logic [`LCDHP_DATA_W-1:0] ramwd_reg, ramwd_next;
  logic [SEG_N-1:0] seg_on_reg, seg_on_next;
  lcdhp_pkg::lcdhp_bias_t [SEG_N-1:0] bias_reg, bias_next;
  logic chip_sel;
  logic rd_sel;
  logic [`LCDHP_DATA_W-1:0] status_byte;
  logic strobe_fall;
  logic is_onoff_cmd;
  logic is_start_cmd;
  logic instr_ok;
  logic [SEG_N-1:0] mapped_bit;
  logic [SEG_N-1:0] lit_bit;

  // A write is taken on the first cycle in which the strobe is seen low after
  // a selected write raised it. The byte used is the one held in wdata_reg.
  // It was sampled while the strobe was still high, so it is settled.
  // The host must not move the bus while the strobe is high.
  assign strobe_fall = (phase_reg == lcdhp_pkg::LCDHP_HIGH) && !bus_in.strobe;

  // Instruction decode on the captured byte.
  // Only the display on/off and the start-line instructions touch state here.
  // Every other code falls through, so it can never disturb the display state.
  assign is_onoff_cmd = (wdata_reg & `LCDHP_OP_ONOFF_MASK) == `LCDHP_OP_ONOFF;
  assign is_start_cmd = (wdata_reg & `LCDHP_OP_START_MASK) == `LCDHP_OP_START;

  // Instructions are refused while the reset pin is held low.
  // Data writes still reach the RAM port in that time.
  // The register-select level comes from the copy taken while the strobe was high.
  assign instr_ok = strobe_fall && !rs_reg && reset_low_input_n_in;

  // Chip select decode and read qualification.
  // All three selects must agree before anything on the bus is acted upon.
  // An unselected access leaves every piece of state untouched except dout_reg, oe_reg and the segment registers, which reload every cycle.
  assign chip_sel = !bus_in.select_low_a && !bus_in.select_low_b && bus_in.select_high_c;
  assign rd_sel = chip_sel && bus_in.rd_wr && bus_in.strobe;

  // Status byte: display off flag and reset flag; busy is never set here.
  // Instructions take effect in a single cycle, so the host never has to wait.
  // The reset flag follows the pin directly, so the host sees it while held.
  always_comb begin
    status_byte = '0;
    status_byte[`LCDHP_ST_ONOFF] = !disp_on_reg;
    status_byte[`LCDHP_ST_RESET] = !reset_low_input_n_in;
  end

  // Bus phase, write capture at the strobe fall and instruction execution.
  // The idle phase waits for a selected write strobe.
  // The high phase keeps sampling the bus until the strobe drops.
  // A read never enters the high phase, so it can never cause a write.
  always_comb begin
    phase_next = phase_reg;
    wdata_next = wdata_reg;
    rs_next = rs_reg;
    disp_on_next = disp_on_reg;
    start_next = start_reg;
    ramwr_next = 1'b0;
    ramwd_next = ramwd_reg;
    case (phase_reg)
      lcdhp_pkg::LCDHP_IDLE: begin
        if (bus_in.strobe && chip_sel && !bus_in.rd_wr) begin
          phase_next = lcdhp_pkg::LCDHP_HIGH;
        end
      end
      lcdhp_pkg::LCDHP_HIGH: begin
        wdata_next = host_data_bus_in;
        rs_next = bus_in.reg_sel;
        if (strobe_fall) begin
          phase_next = lcdhp_pkg::LCDHP_IDLE;
          if (rs_reg) begin
            ramwr_next = 1'b1;
            ramwd_next = wdata_reg;
          end else if (instr_ok) begin
            if (is_onoff_cmd) begin
              disp_on_next = wdata_reg[`LCDHP_ONOFF_BIT];
            end else if (is_start_cmd) begin
              start_next = wdata_reg[`LCDHP_LINE_W-1:0];
            end
          end
        end
      end
      default: phase_next = lcdhp_pkg::LCDHP_IDLE;
    endcase
    // The reset pin wins over any instruction that completes in the same cycle.
    // It holds both registers at their reset values for as long as it is low.
    if (!reset_low_input_n_in) begin
      disp_on_next = `LCDHP_DISP_ON_RST;
      start_next = `LCDHP_START_RST;
    end
  end

  // Read drive: data or status while the selected strobe is high.
  // The enable lags the strobe by one cycle, both when it rises and when it falls.
  // The host must sample the bus late in the high phase.
  // Outside a selected read the enable is low, so the pins are released.
  always_comb begin
    oe_next = rd_sel;
    dout_next = bus_in.reg_sel ? ram_read_data_in : status_byte;
  end

  // Column order picks which RAM bit feeds each output.
  // The display-off state masks every bit.
  // The panel then shows only off dots and the RAM contents are kept.
  for (genvar g = 0; g < SEG_N; g++) begin : g_seg
    assign mapped_bit[g] = column_order_in ? ram_row_in[g] : ram_row_in[SEG_N-1-g];
    assign lit_bit[g] = mapped_bit[g] && disp_on_reg;
  end

  // Bias selection per output, from the lit bit and the alternation level.
  // The alternation input moves lit outputs between V0 and V5 and unlit outputs between V3 and V2.
  // This keeps the average drive across the liquid crystal at zero.
  always_comb begin
    seg_on_next = lit_bit;
    for (int i = 0; i < SEG_N; i++) begin
      if (alternation_in) begin
        bias_next[i] = lit_bit[i] ? `LCDHP_BIAS_V0 : `LCDHP_BIAS_V3;
      end else begin
        bias_next[i] = lit_bit[i] ? `LCDHP_BIAS_V5 : `LCDHP_BIAS_V2;
      end
    end
  end

  // Register all state.
  // The block reset puts the segments on the mid bias level with the display off.
  // It also releases the data bus, so nothing is driven until the host asks.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      phase_reg <= lcdhp_pkg::LCDHP_IDLE;
      wdata_reg <= '0;
      rs_reg <= 1'b0;
      disp_on_reg <= `LCDHP_DISP_ON_RST;
      start_reg <= `LCDHP_START_RST;
      dout_reg <= '0;
      oe_reg <= 1'b0;
      ramwr_reg <= 1'b0;
      ramwd_reg <= '0;
      seg_on_reg <= '0;
      bias_reg <= {SEG_N{`LCDHP_BIAS_V2}};
    end else begin
      phase_reg <= phase_next;
      wdata_reg <= wdata_next;
      rs_reg <= rs_next;
      disp_on_reg <= disp_on_next;
      start_reg <= start_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      ramwr_reg <= ramwr_next;
      ramwd_reg <= ramwd_next;
      seg_on_reg <= seg_on_next;
      bias_reg <= bias_next;
    end
  end

  // Host data bus drive, straight from flip-flops.
  assign host_data_bus_out = dout_reg;
  assign host_data_bus_oe_out = oe_reg;

  // RAM write port: a one-cycle pulse with the captured byte.
  assign ram_write_data_out = ramwd_reg;
  assign ram_write_out = ramwr_reg;

  // Display state that the row scan logic uses.
  assign start_line_out = start_reg;
  assign display_on_out = disp_on_reg;

  // Segment drive: the lit flag and the bias code for each output.
  assign segment_on_out = seg_on_reg;
  assign segment_outputs_out = bias_reg;

endmodule

// *** hw/lcdhp_defines.svh ***
`ifndef LCDHP_DEFINES_SVH
`define LCDHP_DEFINES_SVH

// Data bus and segment geometry.
`define LCDHP_DATA_W 8
`define LCDHP_SEG_N 64
`define LCDHP_LINE_W 6

// Reset values.
`define LCDHP_DISP_ON_RST 1'b0
`define LCDHP_START_RST 6'h00

// Instruction decode (register select low, write).
`define LCDHP_OP_ONOFF_MASK 8'hFE
`define LCDHP_OP_ONOFF 8'h3E
`define LCDHP_OP_START_MASK 8'hC0
`define LCDHP_OP_START 8'hC0
`define LCDHP_OP_YADDR 8'h40
`define LCDHP_ONOFF_BIT 0

// Status byte positions.
`define LCDHP_ST_ONOFF 5
`define LCDHP_ST_RESET 4

// Bias level codes.
`define LCDHP_BIAS_V0 2'h0
`define LCDHP_BIAS_V2 2'h1
`define LCDHP_BIAS_V3 2'h2
`define LCDHP_BIAS_V5 2'h3

`endif

// *** hw/lcdhp_pkg.sv ***
package lcdhp_pkg;
  typedef logic [1:0] lcdhp_bias_t;

  // Host bus strobes and selects sampled together.
  typedef struct packed {
    logic select_low_a;
    logic select_low_b;
    logic select_high_c;
    logic rd_wr;
    logic reg_sel;
    logic strobe;
  } lcdhp_bus_s;

  typedef enum logic [1:0] {
    LCDHP_IDLE = 2'b01,
    LCDHP_HIGH = 2'b10
  } lcdhp_phase_e;
endpackage
